// *** design/bcx_engine.sv ***
/*
  Block copy engine: main store to external store or large core extension.
  Assumes issue control, memory control and both stores share mclk_i;
  only the processor index strap comes from a pin.
*/
module bcx_engine
  import bcx_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Issue control
  input  wire logic              pipe_idle_i,
  input  wire logic              xj_req_i,
  output logic                   issue_hold_o,
  output logic                   halt_others_o,
  output logic                   done_o,
  output logic                   illegal_o,
  output logic                   flag_op_o,
  output logic      [BR_W-1:0]   exit_addr_o,
  output logic                   exit_next_parcel_o,
  // Main store read side
  output logic                   ms_req_o,
  output logic      [LEN_W-1:0]  ms_addr_o,
  input  wire logic              ms_ack_i,
  input  wire logic [WORD_W-1:0] ms_rdata_i,
  input  wire logic              io_req_i,
  // Destination store write side
  output logic                   dst_req_o,
  output logic                   dst_lc_o,
  output logic      [EXT_W-1:0]  dst_addr_o,
  output logic      [WORD_W-1:0] dst_wdata_o,
  input  wire logic              dst_ack_i,
  input  wire logic [ERR_W-1:0]  err_i,
  // Arbitration between processors
  input  wire logic              cp_index_i,
  input  wire logic              peer_req_i
);
  bcx_state_t st_q, st_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [STS_W-1:0]  sts_q, sts_d;
  logic [LEN_W-1:0]  msaddr_q, msaddr_d, index_q, index_d, imm_q, imm_d, p_q, p_d;
  logic [EXT_W-1:0]  extadr_q, extadr_d;
  logic [FL_W-1:0]   base_q, base_d, flim_q, flim_d;
  logic [BR_W-1:0]   branch_q, branch_d, exit_q, exit_d;
  logic [LEN_W-1:0]  rem_q, rem_d, src_q, src_d, moved_q, moved_d;
  logic [EXT_W-1:0]  dst_q, dst_d;
  logic [WORD_W-1:0] data_q, data_d;
  logic [2:0]        pace_q, pace_d;
  logic              io_hold_q, nextp_q, nextp_d, ack_q, cp_s1_q, cp_one_q;
  logic [31:0]       rdat_q, rdat_d;
  logic [LEN_W-1:0]  len_sum;
  logic [CNT_W-1:0]  len_cnt;
  logic              len_zero, len_neg;
  logic              acc, wr, go, ill, lc, xfer, rd_ok, dst_ok, err_any, xj_abort;
  logic              ev_done, ev_ill, ev_err, ev_pass, ev_flag, ev_abort, ev_range;
  logic [EXT_W-1:0]  lc_end;

  // Merge a write under the Wishbone byte selects
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Normal exit address for either variant
  function automatic logic [BR_W-1:0] exit_normal(input logic [LEN_W-1:0] p,
                                                  input logic is_lc, input logic ctl);
    if (is_lc && ctl) begin
      return {{(BR_W-LEN_W){1'b0}}, p};
    end
    return {{(BR_W-LEN_W){1'b0}}, p} + 30'h0000_0001;
  endfunction

  // Illegal when the selected variant's store is missing, or on the external variant when parcel 0 is not held
  function automatic logic illegal_ctrl(input logic [CTRL_W-1:0] c);
    if (c[CB_LC]) begin
      return !c[CB_LCINST];
    end
    return !c[CB_EXTPRES] || !c[CB_PARCEL0];
  endfunction

  bcx_len_calc u_len (
    .index_i (index_q),
    .imm_i   (imm_q),
    .sum_o   (len_sum),
    .zero_o  (len_zero),
    .neg_o   (len_neg),
    .cnt_o   (len_cnt)
  );

  // Bus decode; parameter writes are refused while a copy runs
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = acc && wb_we_i;
  assign go  = wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] && wb_dat_i[CB_GO]
               && (st_q == ST_IDLE);
  assign lc  = ctrl_q[CB_LC];
  // The go write carries the new control byte, so legality is judged from it
  assign ill = illegal_ctrl(wb_dat_i[CTRL_W-1:0]);
  assign xfer = (st_q == ST_RD) || (st_q == ST_WR);
  assign err_any = |err_i;
  assign xj_abort = !lc && xj_req_i && (rem_q > 18'h0_0001);
  assign rd_ok = !io_req_i && !io_hold_q && (pace_q == 3'h0);
  assign dst_ok = lc || !(cp_one_q && peer_req_i);
  assign lc_end = {3'h0, extadr_q[LCA_W-1:0]} + {6'h00, len_sum};

  always_comb begin
    ctrl_d   = ctrl_q;
    msaddr_d = msaddr_q;
    extadr_d = extadr_q;
    index_d  = index_q;
    imm_d    = imm_q;
    base_d   = base_q;
    flim_d   = flim_q;
    branch_d = branch_q;
    p_d      = p_q;
    sts_d    = sts_q;
    rdat_d   = rdat_q;
    if (wr && (st_q == ST_IDLE)) begin
      unique case (wb_adr_i)
        ADR_CTRL:   ctrl_d   = CTRL_W'(merge({24'h00_0000, ctrl_q}, wb_dat_i, wb_sel_i))
                               & ~CTRL_W'(8'h01);
        ADR_MSADDR: msaddr_d = LEN_W'(merge({14'h0000, msaddr_q}, wb_dat_i, wb_sel_i));
        ADR_EXTADR: extadr_d = EXT_W'(merge({8'h00, extadr_q}, wb_dat_i, wb_sel_i));
        ADR_INDEX:  index_d  = LEN_W'(merge({14'h0000, index_q}, wb_dat_i, wb_sel_i));
        ADR_IMM:    imm_d    = LEN_W'(merge({14'h0000, imm_q}, wb_dat_i, wb_sel_i));
        ADR_BASE:   base_d   = FL_W'(merge({10'h000, base_q}, wb_dat_i, wb_sel_i));
        ADR_FLIM:   flim_d   = FL_W'(merge({10'h000, flim_q}, wb_dat_i, wb_sel_i));
        ADR_BRANCH: branch_d = BR_W'(merge({2'h0, branch_q}, wb_dat_i, wb_sel_i));
        ADR_PADDR:  p_d      = LEN_W'(merge({14'h0000, p_q}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
    // Write one to clear; a same-cycle event still sets its flag
    if (wr && (wb_adr_i == ADR_STATUS) && wb_sel_i[0]) begin
      sts_d[7:1] = sts_q[7:1] & ~wb_dat_i[7:1];
    end
    sts_d[SB_DONE]  = sts_d[SB_DONE]  | ev_done;
    sts_d[SB_ILL]   = sts_d[SB_ILL]   | ev_ill;
    sts_d[SB_ERR]   = sts_d[SB_ERR]   | ev_err;
    sts_d[SB_PASS]  = sts_d[SB_PASS]  | ev_pass;
    sts_d[SB_FLAG]  = sts_d[SB_FLAG]  | ev_flag;
    sts_d[SB_ABORT] = sts_d[SB_ABORT] | ev_abort;
    sts_d[SB_RANGE] = sts_d[SB_RANGE] | ev_range;
    sts_d[SB_BUSY]  = (st_d != ST_IDLE);
    sts_d[SB_NEXTP] = nextp_d;
    if (acc) begin
      unique case (wb_adr_i)
        ADR_CTRL:   rdat_d = {24'h00_0000, ctrl_q};
        ADR_STATUS: rdat_d = {23'h00_0000, sts_q};
        ADR_MSADDR: rdat_d = {14'h0000, msaddr_q};
        ADR_EXTADR: rdat_d = {8'h00, extadr_q};
        ADR_INDEX:  rdat_d = {14'h0000, index_q};
        ADR_IMM:    rdat_d = {14'h0000, imm_q};
        ADR_BASE:   rdat_d = {10'h000, base_q};
        ADR_FLIM:   rdat_d = {10'h000, flim_q};
        ADR_BRANCH: rdat_d = {2'h0, branch_q};
        ADR_PADDR:  rdat_d = {14'h0000, p_q};
        ADR_EXIT:   rdat_d = {2'h0, exit_q};
        ADR_MOVED:  rdat_d = {14'h0000, moved_q};
        default:    rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    st_d     = st_q;
    rem_d    = rem_q;
    src_d    = src_q;
    dst_d    = dst_q;
    data_d   = data_q;
    moved_d  = moved_q;
    exit_d   = exit_q;
    nextp_d  = nextp_q;
    pace_d   = (pace_q != 3'h0) ? pace_q - 3'h1 : 3'h0;
    ev_done  = 1'b0;
    ev_ill   = 1'b0;
    ev_err   = 1'b0;
    ev_pass  = 1'b0;
    ev_flag  = 1'b0;
    ev_abort = 1'b0;
    ev_range = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (go) begin
          moved_d = '0;
          nextp_d = 1'b0;
          if (ill) begin
            ev_ill = 1'b1;
            st_d   = ST_FIN;
          end else begin
            st_d = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (pipe_idle_i) begin
          exit_d  = exit_normal(p_q, lc, ctrl_q[CB_EXITCTL]);
          nextp_d = lc && ctrl_q[CB_EXITCTL];
          src_d   = msaddr_q;
          st_d    = ST_FIN;
          if (!lc && extadr_q[FLAG_BIT] && ctrl_q[CB_SFL23] && !len_neg) begin
            ev_flag = 1'b1;
          end else if (len_zero) begin
            ev_pass = 1'b1;
          end else if (!lc && len_neg) begin
            ev_range = 1'b1;
            if (ctrl_q[CB_EXMODE]) begin
              exit_d = branch_q;
              ev_err = 1'b1;
            end
          end else if (lc && (lc_end > {2'h0, flim_q})) begin
            ev_range = 1'b1;
            ev_err   = 1'b1;
          end else if (lc && (len_cnt == '0)) begin
            ev_pass = 1'b1;
          end else begin
            rem_d = lc ? {8'h00, len_cnt} : len_sum;
            dst_d = lc ? EXT_W'({2'h0, base_q} + {3'h0, extadr_q[LCA_W-1:0]})
                       : extadr_q;
            st_d  = ST_RD;
          end
        end
      end
      ST_RD, ST_WR: begin
        if (err_any) begin
          ev_err = 1'b1;
          exit_d = lc ? exit_q : branch_q;
          st_d   = ST_FIN;
        end else if (xj_abort) begin
          ev_abort = 1'b1;
          exit_d   = {{(BR_W-LEN_W){1'b0}}, p_q};
          nextp_d  = 1'b0;
          st_d     = ST_FIN;
        end else if ((st_q == ST_RD) && ms_req_o && ms_ack_i) begin
          data_d = ms_rdata_i;
          st_d   = ST_WR;
        end else if ((st_q == ST_WR) && dst_req_o && dst_ack_i) begin
          rem_d   = rem_q - 18'h0_0001;
          src_d   = src_q + 18'h0_0001;
          dst_d   = dst_q + 24'h00_0001;
          moved_d = moved_q + 18'h0_0001;
          pace_d  = lc ? 3'h0 : WORD_CYC - 3'h1;
          st_d    = (rem_q == 18'h0_0001) ? ST_FIN : ST_RD;
        end
      end
      ST_FIN: begin
        ev_done = 1'b1;
        st_d    = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      ctrl_q <= CTRL_RST;
      sts_q <= STS_RST;
      {msaddr_q, index_q, imm_q, p_q, rem_q, src_q, moved_q} <= '0;
      {extadr_q, dst_q, base_q, flim_q, branch_q, exit_q} <= '0;
      data_q <= '0;
      pace_q <= 3'h0;
      {io_hold_q, nextp_q, ack_q, cp_s1_q, cp_one_q} <= 5'h00;
      rdat_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      sts_q <= sts_d;
      {msaddr_q, index_q, imm_q, p_q} <= {msaddr_d, index_d, imm_d, p_d};
      {rem_q, src_q, moved_q} <= {rem_d, src_d, moved_d};
      {extadr_q, dst_q, base_q, flim_q} <= {extadr_d, dst_d, base_d, flim_d};
      {branch_q, exit_q} <= {branch_d, exit_d};
      data_q <= data_d;
      pace_q <= pace_d;
      io_hold_q <= io_req_i && xfer;
      nextp_q <= nextp_d;
      ack_q <= acc;
      cp_s1_q <= cp_index_i;
      cp_one_q <= cp_s1_q;
      rdat_q <= rdat_d;
    end
  end

  // Issue is released early on the large core path: the last word is in flight
  assign issue_hold_o  = (st_q != ST_IDLE)
                         && !(lc && xfer && (rem_q <= 18'h0_0001));
  assign halt_others_o = lc && xfer;
  assign ms_req_o      = (st_q == ST_RD) && rd_ok && !err_any && !xj_abort;
  assign ms_addr_o     = src_q;
  assign dst_req_o     = (st_q == ST_WR) && dst_ok && !err_any && !xj_abort;
  assign dst_lc_o      = lc;
  assign dst_addr_o    = dst_q;
  assign dst_wdata_o   = data_q;
  assign done_o        = (st_q == ST_FIN);
  assign illegal_o     = sts_q[SB_ILL];
  assign flag_op_o     = sts_q[SB_FLAG];
  assign exit_addr_o   = exit_q;
  assign exit_next_parcel_o = nextp_q;
  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdat_q;

  sequence s_finish;
    (st_q == ST_FIN) ##1 (st_q == ST_IDLE);
  endsequence

  chk_drain_wait: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (st_q == ST_DRAIN && !pipe_idle_i) |=> (st_q == ST_DRAIN) && !ms_req_o)
    else $error("copy started before the pipe drained");
  chk_word_space: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (dst_req_o && dst_ack_i && !lc) |=> !(dst_req_o && dst_ack_i) [*4])
    else $error("external store words closer than 100 ns");
  chk_zero_pass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (st_q == ST_DRAIN && pipe_idle_i && len_zero && !lc && !extadr_q[FLAG_BIT])
    |=> s_finish ##0 (exit_q == exit_normal(p_q, 1'b0, 1'b0)))
    else $error("zero length did not take the full exit");
  chk_illegal_go: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (go && ill) |=> s_finish ##0 sts_q[SB_ILL] && (moved_q == '0))
    else $error("illegal copy not flagged");
  chk_err_branch: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (xfer && err_any && !lc) |=> (exit_q == branch_q) && (st_q == ST_FIN))
    else $error("error did not exit to the branch");
  chk_xj_restore: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (xfer && xj_abort && !err_any) |=> (exit_q[LEN_W-1:0] == p_q) ##1 sts_q[SB_ABORT])
    else $error("exchange jump did not restore the address");
  chk_params_kept: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    xfer |=> $stable(msaddr_q) && $stable(extadr_q) && $stable(index_q))
    else $error("parameter register changed during copy");
  chk_lc_exit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (st_q == ST_DRAIN && pipe_idle_i && lc && ctrl_q[CB_EXITCTL])
    |=> nextp_q && (exit_q[LEN_W-1:0] == p_q))
    else $error("exit control did not continue at next parcel");
  chk_io_pause: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (st_q == ST_RD && io_req_i) |-> !ms_req_o ##1 !ms_req_o)
    else $error("word stream not paused for the I/O request");
  chk_cp_prio: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (dst_req_o && !lc) |-> !(cp_one_q && peer_req_i))
    else $error("processor 1 requested over processor 0");
  chk_near_done: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (halt_others_o && rem_q == 18'h0_0001) |-> !issue_hold_o)
    else $error("issue not released near completion");
endmodule

// *** design/bcx_len_calc.sv ***
/*
  Block length adder: 18-bit one's complement sum of index and immediate.
  Purely combinational; the caller registers whatever it keeps.
*/
module bcx_len_calc
  import bcx_pkg::*;
(
  // Operands
  input  wire logic [LEN_W-1:0] index_i,
  input  wire logic [LEN_W-1:0] imm_i,
  // Results
  output logic      [LEN_W-1:0] sum_o,
  output logic                  zero_o,
  output logic                  neg_o,
  output logic      [CNT_W-1:0] cnt_o
);
  logic [LEN_W:0] raw;
  logic           all_ones;

  // End-around carry gives the one's complement sum
  always_comb begin
    raw      = {1'b0, index_i} + {1'b0, imm_i};
    sum_o    = raw[LEN_W-1:0] + {{(LEN_W-1){1'b0}}, raw[LEN_W]};
    all_ones = &sum_o;
    // Both +0 and -0 count as a zero length
    zero_o   = (sum_o == '0) || all_ones;
    neg_o    = sum_o[LEN_W-1] && !all_ones;
    // Large core store keeps only the low ten bits, silently
    cnt_o    = sum_o[CNT_W-1:0];
  end
endmodule

// *** shared/bcx_pkg.sv ***
/*
  Constants, register map and state encoding for the block copy engine.
  Assumes a 50 MHz processor clock and a 32-bit classic Wishbone register bus.
*/
package bcx_pkg;
  // Data widths
  localparam int WORD_W = 60;
  localparam int LEN_W  = 18;
  localparam int CNT_W  = 10;
  localparam int EXT_W  = 24;
  localparam int LCA_W  = 21;
  localparam int FL_W   = 22;
  localparam int BR_W   = 30;
  localparam int ERR_W  = 7;

  // Timing: least spacing of external store words
  localparam int CLK_PERIOD_NS = 20;
  localparam int WORD_TIME_NS  = 100;
  localparam logic [2:0] WORD_CYC =
    3'((WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MSADDR = 8'h08;
  localparam logic [7:0] ADR_EXTADR = 8'h0c;
  localparam logic [7:0] ADR_INDEX  = 8'h10;
  localparam logic [7:0] ADR_IMM    = 8'h14;
  localparam logic [7:0] ADR_BASE   = 8'h18;
  localparam logic [7:0] ADR_FLIM   = 8'h1c;
  localparam logic [7:0] ADR_BRANCH = 8'h20;
  localparam logic [7:0] ADR_PADDR  = 8'h24;
  localparam logic [7:0] ADR_EXIT   = 8'h28;
  localparam logic [7:0] ADR_MOVED  = 8'h2c;

  // Control register fields
  localparam int CB_GO      = 0;
  localparam int CB_LC      = 1;
  localparam int CB_EXMODE  = 2;
  localparam int CB_EXITCTL = 3;
  localparam int CB_EXTPRES = 4;
  localparam int CB_LCINST  = 5;
  localparam int CB_SFL23   = 6;
  localparam int CB_PARCEL0 = 7;
  localparam int CTRL_W     = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // Status register fields
  localparam int SB_BUSY  = 0;
  localparam int SB_DONE  = 1;
  localparam int SB_ILL   = 2;
  localparam int SB_ERR   = 3;
  localparam int SB_PASS  = 4;
  localparam int SB_FLAG  = 5;
  localparam int SB_ABORT = 6;
  localparam int SB_RANGE = 7;
  localparam int SB_NEXTP = 8;
  localparam int STS_W    = 9;
  localparam logic [STS_W-1:0] STS_RST = 9'h000;

  // External address bit that selects a flag register operation
  localparam int FLAG_BIT = 23;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_DRAIN = 5'h02,
    ST_RD    = 5'h04,
    ST_WR    = 5'h08,
    ST_FIN   = 5'h10
  } bcx_state_t;
endpackage

// *** testbench/bcx_store_model.sv ***
/*
  Memory control and destination store model for the copy engine.
  Assumes the engine holds each request until it samples the ack.
*/
module bcx_store_model
  import bcx_pkg::*;
#(
  parameter int DLY = 1
)(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // Engine requests
  input  wire logic              ms_req_i,
  input  wire logic [LEN_W-1:0]  ms_addr_i,
  input  wire logic              dst_req_i,
  // Answers
  output logic                   ms_ack_o,
  output logic      [WORD_W-1:0] ms_rdata_o,
  output logic                   dst_ack_o
);
  logic [3:0] wait_q;
  // Data only valid with the ack; the inverse elsewhere exposes early sampling
  assign ms_rdata_o = ms_ack_o ? {42'h0, ms_addr_i} : ~{42'h0, ms_addr_i};
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wait_q    <= 4'h0;
      ms_ack_o  <= 1'b0;
      dst_ack_o <= 1'b0;
    end else begin
      wait_q    <= ((ms_req_i | dst_req_i) & ~(ms_ack_o | dst_ack_o)) ? wait_q + 4'h1 : 4'h0;
      ms_ack_o  <= ms_req_i & ~ms_ack_o & (wait_q >= 4'(DLY));
      dst_ack_o <= dst_req_i & ~dst_ack_o & (wait_q >= 4'(DLY));
    end
  end
endmodule

// *** testbench/testbench.sv ***
/*
  Self-checking bench for the block copy engine.
  Assumes the store model answers every request within a few cycles.
*/
module testbench
  import bcx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] MSA = 18'h0_0040;
  localparam logic [17:0] P   = 18'h0_0100;
  localparam logic [23:0] EXT = 24'h00_0200;
  localparam logic [21:0] BAS = 22'h00_1000;
  localparam logic [29:0] BR  = 30'h0abc_0123;
  localparam logic [7:0]  CE  = 8'h90;
  localparam logic [7:0]  CL  = 8'h22;
  logic              mclk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0, wb_ack_o, pipe_idle_i = 1'b1, xj_req_i = 1'b0;
  logic              issue_hold_o, halt_others_o, done_o, illegal_o, flag_op_o, ms_req_o;
  logic              exit_next_parcel_o, ms_ack_i, io_req_i = 1'b0, dst_req_o, dst_lc_o;
  logic              dst_ack_i, cp_index_i = 1'b0, peer_req_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'hf;
  logic [31:0]       wb_dat_i = 32'h0000_0000, wb_dat_o, rd, sts;
  logic [BR_W-1:0]   exit_addr_o;
  logic [LEN_W-1:0]  ms_addr_o;
  logic [WORD_W-1:0] ms_rdata_i, dst_wdata_o, last_wdata;
  logic [EXT_W-1:0]  dst_addr_o, last_addr;
  logic [ERR_W-1:0]  err_i = 7'h00;
  int err_count = 0, checked = 0, cyc_n = 0, last_wr = 0, min_gap = 99, n_wr = 0, n0, early = 0;
  int n_done = 0, d0, io_bad = 0, prio_bad = 0, hold_bad = 0;
  logic              io_q = 1'b0;
  logic [1:0]        pins;
  always #10 mclk_i = ~mclk_i;
  bcx_engine u_bcx_engine (.mclk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pipe_idle_i, .xj_req_i, .issue_hold_o,
    .halt_others_o, .done_o, .illegal_o, .flag_op_o, .exit_addr_o, .exit_next_parcel_o,
    .ms_req_o, .ms_addr_o, .ms_ack_i, .ms_rdata_i, .io_req_i, .dst_req_o, .dst_lc_o,
    .dst_addr_o, .dst_wdata_o, .dst_ack_i, .err_i, .cp_index_i, .peer_req_i);
  bcx_store_model #(.DLY(1)) u_bcx_store_model (.mclk_i, .reset_n_i, .ms_req_i(ms_req_o),
    .ms_addr_i(ms_addr_o), .dst_req_i(dst_req_o), .ms_ack_o(ms_ack_i),
    .ms_rdata_o(ms_rdata_i), .dst_ack_o(dst_ack_i));
  // Watches accepted writes; the gap is only measured on the external path
  always @(posedge mclk_i) begin
    cyc_n <= cyc_n + 1;
    if (ms_req_o === 1'b1 && pipe_idle_i === 1'b0) early <= early + 1;
    io_q <= io_req_i;
    if (done_o === 1'b1) n_done <= n_done + 1;
    if (ms_req_o === 1'b1 && (io_req_i !== 1'b0 || io_q !== 1'b0)) io_bad <= io_bad + 1;
    if (dst_req_o === 1'b1 && peer_req_i === 1'b1 && cp_index_i === 1'b1 && dst_lc_o === 1'b0)
      prio_bad <= prio_bad + 1;
    if (dst_req_o === 1'b1 && (dst_lc_o ? halt_others_o : issue_hold_o) !== 1'b1)
      hold_bad <= hold_bad + 1;
    if (dst_req_o === 1'b1 && dst_ack_i === 1'b1) begin
      n_wr <= n_wr + 1;
      last_addr <= dst_addr_o;
      last_wdata <= dst_wdata_o;
      if (dst_lc_o === 1'b0) begin
        if (last_wr > 0 && cyc_n - last_wr < min_gap) min_gap <= cyc_n - last_wr;
        last_wr <= cyc_n;
      end
    end
    if (cyc_n == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Polls busy over the bus and counts done pulses, so a short illegal run cannot slip past unseen
  task automatic run(input logic [7:0] c, input logic [17:0] idx, input logic [17:0] imm);
    n0 = n_wr;
    d0 = n_done;
    wb(ADR_INDEX, 1'b1, 32'(idx));
    wb(ADR_IMM, 1'b1, 32'(imm));
    wb(ADR_CTRL, 1'b1, {24'h00_0000, c | 8'h01});
    do wb(ADR_STATUS, 1'b0, 32'h0000_0000); while (rd[SB_BUSY] !== 1'b0);
    sts = rd;
    pins = {illegal_o, flag_op_o};
    check(n_done - d0, 1);
    wb(ADR_STATUS, 1'b1, 32'h0000_00fe);
  endtask
  task automatic s_ext();
    pipe_idle_i <= 1'b0;
    fork
      run(CE, 18'h0_0001, 18'h0_0002);
      begin
        repeat (16) @(posedge mclk_i);
        pipe_idle_i <= 1'b1;
      end
    join
    check(exit_addr_o, 30'(P) + 30'h1);
    check(n_wr - n0, 3);
    check(early, 0);
    check(hold_bad, 0);
    check(min_gap >= int'(WORD_CYC), 1);
    check(sts[SB_DONE], 1'b1);
    wb(ADR_INDEX, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
  endtask
  task automatic s_limits();
    run(CE, 18'h0_0000, 18'h0_0000);
    check({sts[SB_PASS], exit_addr_o}, {1'b1, 30'(P) + 30'h1});
    run(CE | 8'h04, 18'h3_fffe, 18'h0_0000);
    check({sts[SB_RANGE], exit_addr_o}, {1'b1, BR});
    run(CE, 18'h3_fffe, 18'h0_0000);
    check(exit_addr_o, 30'(P) + 30'h1);
  endtask
  task automatic s_illegal();
    logic [7:0] c [3] = '{8'h80, 8'h10, 8'h02};
    foreach (c[i]) begin
      run(c[i], 18'h0_0001, 18'h0_0000);
      check({sts[SB_ILL], 5'(n_wr - n0)}, 6'h20);
      check(pins, 2'b10);
    end
  endtask
  task automatic s_err_xj();
    for (int i = 0; i < ERR_W; i++) begin
      err_i <= 7'(1 << i);
      run(CE, 18'h0_0001, 18'h0_0001);
      check({sts[SB_ERR], exit_addr_o}, {1'b1, BR});
    end
    err_i <= 7'h00;
    xj_req_i <= 1'b1;
    run(CE, 18'h0_0004, 18'h0_0000);
    check({sts[SB_ABORT], exit_addr_o}, {1'b1, 30'(P)});
    run(CE, 18'h0_0001, 18'h0_0000);
    check({5'(n_wr - n0), exit_addr_o}, {5'h1, 30'(P) + 30'h1});
    xj_req_i <= 1'b0;
  endtask
  task automatic s_lc();
    run(CL | 8'h08, 18'h0_0003, 18'h0_0000);
    check({exit_next_parcel_o, exit_addr_o}, {1'b1, 30'(P)});
    check(last_addr, 24'(EXT[20:0]) + 24'(BAS) + 24'h00_0002);
    check(last_wdata, {42'h0, MSA + 18'h0_0002});
    run(CL, 18'h0_0003, 18'h0_0000);
    check({exit_next_parcel_o, exit_addr_o}, {1'b0, 30'(P) + 30'h1});
    run(CL, 18'h0_0400, 18'h0_0001);
    check({sts[SB_ERR], 5'(n_wr - n0)}, 6'h01);
    run(CL, 18'h0_2001, 18'h0_0000);
    check(sts[SB_RANGE], 1'b1);
    run(CL, 18'h0_0000, 18'h0_0000);
    check(sts[SB_PASS], 1'b1);
    check(hold_bad, 0);
  endtask
  task automatic s_flag();
    wb(ADR_EXTADR, 1'b1, 32'(EXT) | 32'h0080_0000);
    run(CE | 8'h40, 18'h0_0001, 18'h0_0000);
    check({pins, sts[SB_FLAG], 5'(n_wr - n0)}, 8'h60);
    wb(ADR_EXTADR, 1'b1, 32'(EXT));
  endtask
  task automatic s_arb();
    fork
      run(CL, 18'h0_0004, 18'h0_0000);
      begin
        wait (halt_others_o === 1'b1);
        @(posedge mclk_i);
        io_req_i <= 1'b1;
        @(posedge mclk_i);
        io_req_i <= 1'b0;
      end
    join
    check(io_bad, 0);
    check(n_wr - n0, 4);
    cp_index_i <= 1'b1;
    peer_req_i <= 1'b1;
    fork
      run(CE, 18'h0_0001, 18'h0_0000);
      begin
        repeat (30) @(posedge mclk_i);
        peer_req_i <= 1'b0;
      end
    join
    cp_index_i <= 1'b0;
    check(prio_bad, 0);
    check(n_wr - n0, 1);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wb(ADR_MSADDR, 1'b1, 32'(MSA));
    wb(ADR_EXTADR, 1'b1, 32'(EXT));
    wb(ADR_BASE, 1'b1, 32'(BAS));
    wb(ADR_FLIM, 1'b1, 32'h0000_2000);
    wb(ADR_BRANCH, 1'b1, 32'(BR));
    wb(ADR_PADDR, 1'b1, 32'(P));
    wb(8'h3c, 1'b0, 32'h0000_0000);
    s_ext();
    s_limits();
    s_illegal();
    s_err_xj();
    s_lc();
    s_flag();
    s_arb();
    final_report();
  end
endmodule
